/* File: rtl/piezo_fault_ctrl.v */
/*
  Protection and functional-mode controller of the dual half-bridge driver:
  undervoltage lockouts, latched overcurrent, two thermal shutdowns, sleep and
  wake sequencing on the wake pin, fault-reset pulse, output kill and the
  open-drain fault flag, with an APB register file and one interrupt line.
  Assumes analog comparators deliver synchronous active-high fault levels and
  that the open-drain wire is resolved outside from the enable.
*/
`timescale 1ns/1ns
`default_nettype none
`include "piezo_fault_regs.vh"
module piezo_fault_ctrl #(
  parameter T_SLEEP_NS = `T_SLEEP_NS,
  parameter T_WAKE_NS = `T_WAKE_NS,
  parameter T_RST_NS = `T_RST_NS,
  parameter CMD_DEGLITCH_CYC = `CMD_DEGLITCH_CYC
) (
  input wire clk,
  input wire rst,
  input wire [1:0] half_bridge_cmd,
  input wire sleep_wake_n,
  input wire output_kill,
  input wire main_supply_uv,
  input wire ldo_rail_uv,
  input wire pump_rail_uv,
  input wire overcurrent_trip,
  input wire over_temp_fet,
  input wire over_temp_die,
  input wire fault_flag_in,
  output wire fault_flag_out,
  output reg fault_flag_oe_n,
  output wire [1:0] half_bridge_out,
  output wire fet_enable,
  output reg pump_enable,
  output reg ldo_enable,
  output wire irq,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr
);
  // ****************************************
  // Timing conversion
  // ****************************************
  function [23:0] ns_to_cyc;
    input integer ns;
    integer c;
    begin
      c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
      if (c < 1)
        c = 1;
      ns_to_cyc = c[23:0];
    end
  endfunction

  localparam [23:0] SLEEP_CYC = ns_to_cyc(T_SLEEP_NS);
  localparam [23:0] WAKE_CYC = ns_to_cyc(T_WAKE_NS);
  localparam [23:0] RST_CYC = ns_to_cyc(T_RST_NS);
  localparam OC_CYC = (`OC_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_SLEEP = 3'h1;
  localparam [2:0] ST_WAKE = 3'h2;
  localparam [2:0] ST_RUN = 3'h3;
  localparam [2:0] ST_LOWPEND = 3'h4;
  localparam [2:0] ST_DOWN = 3'h5;

  // Regulators run in every state except lockout and sleep.
  function regs_up;
    input [2:0] st;
    begin
      regs_up = st != ST_OFF && st != ST_SLEEP;
    end
  endfunction

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [23:0] cnt_reg;
  reg [23:0] cnt_next;
  reg clear_latch;
  reg oc_latch_reg;
  reg fet_on_reg;
  reg [1:0] drive_reg;
  reg [`EV_WIDTH-1:0] status_reg;
  reg [`EV_WIDTH-1:0] irq_en_reg;
  reg [`EV_WIDTH-1:0] live_prev_reg;
  reg [31:0] ctrl_reg;
  wire [1:0] cmd_clean;
  wire oc_event;
  wire supply_off;
  wire pump_uv_seen;
  wire any_fault;
  wire flag_low;
  wire drive_ok;
  wire [`EV_WIDTH-1:0] live;
  wire [`EV_WIDTH-1:0] clr_bits;
  wire wr_en;
  wire mapped;

  // ****************************************
  // Input filtering
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_cmd
      cmd_deglitch #(
        .STABLE_CYC(CMD_DEGLITCH_CYC)
      ) u_cmd (
        .clk(clk),
        .rst(rst),
        .din(half_bridge_cmd[i]),
        .dout(cmd_clean[i])
      );
    end
  endgenerate

  // Sensing idles while the FETs are off, including under output kill.
  persist_detect #(
    .HOLD_CYC(OC_CYC)
  ) u_oc (
    .clk(clk),
    .rst(rst),
    .din(overcurrent_trip & fet_enable),
    .trip(oc_event)
  );

  // ****************************************
  // Mode sequencing on the wake pin
  // ****************************************
  assign supply_off = main_supply_uv | ldo_rail_uv;

  always @*
  begin
    state_next = state_reg;
    cnt_next = (cnt_reg == 24'hffffff) ? cnt_reg : cnt_reg + 24'h000001;
    clear_latch = 1'b0;
    if (supply_off)
    begin
      state_next = ST_OFF;
      cnt_next = 24'h000000;
    end
    else
    begin
      case (state_reg)
        ST_OFF:
        begin
          state_next = sleep_wake_n ? ST_WAKE : ST_SLEEP;
          cnt_next = 24'h000000;
        end
        ST_SLEEP:
        begin
          cnt_next = 24'h000000;
          if (sleep_wake_n)
            state_next = ST_WAKE;
        end
        ST_WAKE:
        begin
          if (!sleep_wake_n)
          begin
            state_next = ST_DOWN;
            cnt_next = 24'h000000;
          end
          else if (cnt_reg >= WAKE_CYC - 24'h000001)
          begin
            state_next = ST_RUN;
            cnt_next = 24'h000000;
          end
        end
        ST_RUN:
        begin
          cnt_next = 24'h000000;
          if (!sleep_wake_n)
            state_next = ST_LOWPEND;
        end
        ST_LOWPEND:
        begin
          if (sleep_wake_n)
          begin
            state_next = ST_RUN;
            clear_latch = 1'b1;
            cnt_next = 24'h000000;
          end
          else if (cnt_reg >= RST_CYC - 24'h000001)
            state_next = ST_DOWN;
        end
        ST_DOWN:
        begin
          // The count keeps running from the falling edge of the pin.
          if (sleep_wake_n)
          begin
            state_next = ST_WAKE;
            cnt_next = 24'h000000;
          end
          else if (cnt_reg >= SLEEP_CYC - 24'h000001)
            state_next = ST_SLEEP;
        end
        default:
        begin
          state_next = ST_OFF;
          cnt_next = 24'h000000;
        end
      endcase
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_OFF;
      cnt_reg <= 24'h000000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ****************************************
  // Fault tracking and drive
  // ****************************************
  // A disabled controller forgets the latch; a trip in the clearing cycle still sets it.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      oc_latch_reg <= 1'b0;
    else if (oc_event)
      oc_latch_reg <= 1'b1;
    else if (clear_latch || state_reg == ST_OFF || state_reg == ST_SLEEP)
      oc_latch_reg <= 1'b0;
  end

  // A sagging pump rail only counts while the pump is meant to run.
  assign pump_uv_seen = pump_rail_uv & pump_enable;
  assign any_fault = pump_uv_seen | oc_latch_reg | over_temp_fet | over_temp_die;
  // Kill does not mask any of these, so faults raised under it still reach the flag.
  assign flag_low = any_fault | state_reg == ST_WAKE | state_reg == ST_DOWN;
  // One enable for FETs and drive, so a fault can never leave the outputs driven.
  assign drive_ok = state_next == ST_RUN && !any_fault && ctrl_reg[`CTRL_DRIVE_ALLOW];

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fault_flag_oe_n <= 1'b1;
      pump_enable <= 1'b0;
      ldo_enable <= 1'b0;
      fet_on_reg <= 1'b0;
      drive_reg <= 2'h0;
    end
    else
    begin
      // The flag follows the registered state: on wake it lets go a cycle after the FETs.
      fault_flag_oe_n <= ~flag_low;
      ldo_enable <= regs_up(state_next);
      pump_enable <= regs_up(state_next) && !over_temp_fet &&
        !over_temp_die;
      fet_on_reg <= drive_ok;
      if (drive_ok)
        drive_reg <= cmd_clean;
      else
        drive_reg <= 2'h0;
    end
  end

  assign fault_flag_out = 1'b0;
  // Kill acts directly on the pin-facing enables so no clocked stage can delay it.
  assign fet_enable = fet_on_reg & ~output_kill;
  assign half_bridge_out = drive_reg & {2{~output_kill}};

  // ****************************************
  // Event capture and interrupt
  // ****************************************
  assign live = {output_kill, over_temp_die, over_temp_fet, oc_event,
                 pump_uv_seen, ldo_rail_uv, main_supply_uv};
  assign wr_en = psel & penable & pwrite;
  assign clr_bits = (wr_en && paddr == `REG_IRQ_CLR) ? pwdata[`EV_WIDTH-1:0] :
                    {`EV_WIDTH{1'b0}};

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      live_prev_reg <= {`EV_WIDTH{1'b0}};
      status_reg <= {`EV_WIDTH{1'b0}};
    end
    else
    begin
      live_prev_reg <= live;
      // A new event in the clearing cycle survives the clear.
      status_reg <= (status_reg & ~clr_bits) | (live & ~live_prev_reg);
    end
  end

  assign irq = |(status_reg & irq_en_reg);

  // ****************************************
  // APB slave
  // ****************************************
  assign mapped = paddr == `REG_STATUS || paddr == `REG_IRQ_EN ||
                  paddr == `REG_IRQ_CLR || paddr == `REG_STATE || paddr == `REG_CTRL;
  // No wait states: every register answers in the first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_en_reg <= `IRQ_EN_RESET;
      ctrl_reg <= `CTRL_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == `REG_IRQ_EN)
        irq_en_reg <= pwdata[`EV_WIDTH-1:0];
      if (paddr == `REG_CTRL)
        ctrl_reg <= {31'h00000000, pwdata[`CTRL_DRIVE_ALLOW]};
    end
  end

  // Read data is captured in the setup phase so it is a flop by the access phase.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `REG_STATUS: prdata <= {25'h0000000, status_reg};
        `REG_IRQ_EN: prdata <= {25'h0000000, irq_en_reg};
        `REG_STATE: prdata <= {23'h000000, ldo_enable, pump_enable, fet_enable,
                               fault_flag_in, flag_low, oc_latch_reg, state_reg};
        `REG_CTRL: prdata <= ctrl_reg;
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: rtl/piezo_fault_regs.vh */
/*
  Register map, field positions, reset values and timing figures of the
  protection and mode controller of the dual half-bridge piezo driver.
  Assumes a 100 MHz core clock and a 32-bit APB register bus.
*/
// How it works
// - Each half-bridge command passes a stability filter before reaching the drivers.
// - Main supply undervoltage turns off FETs, pump and controller; resumes by itself.
// - Regulator rail undervoltage turns off FETs, pumps and controller; resumes by itself.
// - Pump rail undervoltage turns off FETs and pulls the fault flag low.
// - Overcurrent held beyond 0.6 us latches a shutdown.
// - Overcurrent latch keeps FETs off and flag low until a reset pulse, sleep or undervoltage lockout.
// - FET-area overtemperature stops FETs and pump, flags, recovers by itself.
// - Second die sensor overtemperature acts the same way, also self-recovering.
// - Wake pin held low leads to sleep after the sleep delay.
// - Wake pin high leaves sleep; commands are honoured after the wake delay.
// - Flag is held low while regulators switch, within the wake or sleep delay.
// - Operating mode only with wake pin high and main supply good.
// - Short low pulse on wake pin is a fault reset; longer means shutdown.
// - Valid reset pulse clears latched faults, leaves regulators untouched.
// - Output kill high turns all FETs off, bypassing the command path.
// - Under output kill with wake high, pump stays on and overcurrent sensing idles.
// - Faults raised while output kill holds the FETs off still pull the flag low.
`ifndef PIEZO_FAULT_REGS_VH
`define PIEZO_FAULT_REGS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define REG_STATUS 8'h00
`define REG_IRQ_EN 8'h04
`define REG_IRQ_CLR 8'h08
`define REG_STATE 8'h0c
`define REG_CTRL 8'h10

// ****************************************
// Status, enable and clear bit layout
// ****************************************
`define EV_MAIN_UV 0
`define EV_LDO_UV 1
`define EV_PUMP_UV 2
`define EV_OC 3
`define EV_OT_FET 4
`define EV_OT_DIE 5
`define EV_KILL 6
`define EV_WIDTH 7

// ****************************************
// Control and state fields, reset values
// ****************************************
`define CTRL_DRIVE_ALLOW 0
`define CTRL_RESET 32'h0000_0001
`define IRQ_EN_RESET 7'h00
`define ST_OC_LATCH 3
`define ST_FLAG_LOW 4
`define ST_FLAG_PIN 5
`define ST_FET_ON 6
`define ST_PUMP_EN 7
`define ST_LDO_EN 8

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 10
`define OC_DEGLITCH_NS 600
`define CMD_DEGLITCH_CYC 4
`define T_SLEEP_NS 100000
`define T_WAKE_NS 100000
`define T_RST_NS 20000

`endif

/* File: rtl/cmd_deglitch.v */
/*
  Stability filter for one command input: the output takes a new level only
  after the input has held it for a set number of cycles.
  Assumes the input is already synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module cmd_deglitch #(
  parameter STABLE_CYC = 4
) (
  input wire clk,
  input wire rst,
  input wire din,
  output reg dout
);
  reg [7:0] cnt_reg;

  // Pulses shorter than the window never reach the output, at the cost of a fixed delay.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 8'h00;
      dout <= 1'b0;
    end
    else if (din == dout)
      cnt_reg <= 8'h00;
    else if (cnt_reg >= STABLE_CYC[7:0] - 8'h01)
    begin
      cnt_reg <= 8'h00;
      dout <= din;
    end
    else
      cnt_reg <= cnt_reg + 8'h01;
  end
endmodule
`default_nettype wire

/* File: rtl/persist_detect.v */
/*
  Persistence detector: raises a trip, held for as long as the input stays high,
  once the input has stayed high for more than a set number of cycles; any low cycle restarts the count.
  Assumes a synchronous input.
*/
`timescale 1ns/1ns
`default_nettype none
module persist_detect #(
  parameter HOLD_CYC = 60
) (
  input wire clk,
  input wire rst,
  input wire din,
  output reg trip
);
  reg [11:0] cnt_reg;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 12'h000;
      trip <= 1'b0;
    end
    else
    begin
      trip <= 1'b0;
      if (!din)
        cnt_reg <= 12'h000;
      else if (cnt_reg == HOLD_CYC[11:0])
        trip <= 1'b1;
      else
        cnt_reg <= cnt_reg + 12'h001;
    end
  end
endmodule
`default_nettype wire

/* File: dv/piezo_fault_ctrl_sva.sv */
/*
  Pin-level assertions for the piezo protection and mode controller.
  Assumes one clock domain with an active-high asynchronous reset; bound by the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module piezo_fault_ctrl_sva #(
  parameter T_SLEEP_NS = 100000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] half_bridge_cmd,
  input wire logic sleep_wake_n,
  input wire logic output_kill,
  input wire logic main_supply_uv,
  input wire logic ldo_rail_uv,
  input wire logic pump_rail_uv,
  input wire logic overcurrent_trip,
  input wire logic over_temp_fet,
  input wire logic over_temp_die,
  input wire logic fault_flag_oe_n,
  input wire logic [1:0] half_bridge_out,
  input wire logic fet_enable,
  input wire logic pump_enable,
  input wire logic ldo_enable
);
  localparam int SLP = T_SLEEP_NS / 10;
  int oc_cnt, lat_age, low_cnt;
  default clocking dclk @(posedge clk);
  endclocking
  default disable iff (rst);
  // ****************************************
  // Helper counters
  // ****************************************
  // The overcurrent filter and the sleep delay outrun any repetition, so count them.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      oc_cnt <= 0;
      lat_age <= 0;
      low_cnt <= 0;
    end
    else
    begin
      oc_cnt <= (overcurrent_trip && fet_enable) ? oc_cnt + 1 : 0;
      low_cnt <= sleep_wake_n ? 0 : low_cnt + 1;
      if (!sleep_wake_n || main_supply_uv || ldo_rail_uv)
        lat_age <= 0;
      else if ((lat_age > 0 || oc_cnt >= 61) && lat_age < 9)
        lat_age <= lat_age + 1;
    end
  end
  property p_kill; output_kill |-> !fet_enable && half_bridge_out == 2'b00; endproperty
  a_kill: assert property (p_kill) else $error("FET on under kill");
  property p_uv;
    (main_supply_uv || ldo_rail_uv) |-> ##[1:2] !(fet_enable || pump_enable || ldo_enable);
  endproperty
  a_uv: assert property (p_uv) else $error("lockout left a stage on");
  property p_pump;
    pump_rail_uv && pump_enable |-> ##[1:2] !fet_enable && !fault_flag_oe_n;
  endproperty
  a_pump: assert property (p_pump) else $error("pump rail low not handled");
  property p_oc_trip; oc_cnt == 61 |-> ##[1:4] !fet_enable && !fault_flag_oe_n; endproperty
  a_oc_trip: assert property (p_oc_trip) else $error("overcurrent not tripped");
  property p_oc_hold; lat_age >= 5 |-> !fet_enable && !fault_flag_oe_n; endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("latch released early");
  property p_heat;
    (over_temp_fet || over_temp_die) |->
      ##[1:2] !(fet_enable || pump_enable || fault_flag_oe_n);
  endproperty
  a_heat: assert property (p_heat) else $error("thermal trip not handled");
  property p_follow;
    (fet_enable && $stable(half_bridge_cmd)) [*6] |-> half_bridge_out == half_bridge_cmd;
  endproperty
  a_follow: assert property (p_follow) else $error("output ignores command");
  property p_wake; $rose(ldo_enable) |-> ##[1:2] !fault_flag_oe_n; endproperty
  a_wake: assert property (p_wake) else $error("flag not held on wake");
  property p_sleep; low_cnt == SLP + 3 |-> !(ldo_enable || pump_enable || fet_enable); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  c_oc: cover property (oc_cnt == 61);
  c_sleep: cover property (low_cnt == SLP + 3);
  c_kill: cover property (output_kill && pump_enable);
endmodule
`default_nettype wire

/* File: dv/pwm_host.sv */
/*
  Model of the external controller: drives commands, wake pin and kill pin.
  Assumes the bench calls its tasks one at a time; holds the flag pull-up.
*/
`timescale 1ns/1ns
`default_nettype none
module pwm_host #(
  parameter WAKE_CYC = 10000
) (
  input wire logic clk,
  input wire logic fault_flag_out,
  input wire logic fault_flag_oe_n,
  output wire logic fault_flag_in,
  output var logic [1:0] half_bridge_cmd,
  output var logic sleep_wake_n,
  output var logic output_kill
);
  // Pull-up on the open-drain wire: a released flag reads high.
  assign fault_flag_in = fault_flag_oe_n ? 1'b1 : fault_flag_out;
  initial
  begin
    half_bridge_cmd = 2'b00;
    sleep_wake_n = 1'b1;
    output_kill = 1'b0;
  end
  task automatic drive(input logic [1:0] c, input logic k);
    @(posedge clk);
    half_bridge_cmd <= c;
    output_kill <= k;
  endtask
  task automatic pin(input logic v);
    @(posedge clk);
    sleep_wake_n <= v;
  endtask
  // Low phase must stay inside the reset window, or the device shuts down.
  task automatic pulse(input int n);
    pin(1'b0);
    repeat (n) @(posedge clk);
    sleep_wake_n <= 1'b1;
  endtask
  task automatic wake_up;
    pin(1'b1);
    repeat (WAKE_CYC + 2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
/*
  Self-checking bench of the piezo protection and mode controller.
  Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int WK = 1000;
  logic clk, rst, psel, penable, pwrite, err, oc;
  logic [4:0] flt;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  wire [1:0] half_bridge_cmd, half_bridge_out;
  wire [31:0] prdata;
  wire sleep_wake_n, output_kill, fault_flag_in, fault_flag_out, fault_flag_oe_n;
  wire fet_enable, pump_enable, ldo_enable, irq, pready, pslverr;
  int error_cnt = 0;
  int cmp_count = 0;
  int i;
  // Pin view {fet, pump, ldo, flag} while main, ldo, pump, FET-heat, die-heat fault holds.
  logic [3:0] flt_exp [5] = '{4'b0001, 4'b0001, 4'b0110, 4'b0010, 4'b0010};
  piezo_fault_ctrl #(.T_SLEEP_NS(2000), .T_WAKE_NS(WK), .T_RST_NS(500), .CMD_DEGLITCH_CYC(4))
    u_piezo_fault_ctrl (.clk, .rst, .half_bridge_cmd, .sleep_wake_n, .output_kill,
    .main_supply_uv(flt[0]), .ldo_rail_uv(flt[1]), .pump_rail_uv(flt[2]),
    .overcurrent_trip(oc), .over_temp_fet(flt[3]), .over_temp_die(flt[4]),
    .fault_flag_in, .fault_flag_out, .fault_flag_oe_n, .half_bridge_out, .fet_enable,
    .pump_enable, .ldo_enable, .irq, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  pwm_host #(.WAKE_CYC(WK / 10)) u_pwm_host (.clk, .fault_flag_out, .fault_flag_oe_n,
    .fault_flag_in, .half_bridge_cmd, .sleep_wake_n, .output_kill);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_pins(input logic [3:0] e);
    chk_reg({28'h0, fet_enable, pump_enable, ldo_enable, fault_flag_in}, {28'h0, e});
  endtask
  task automatic chk_out(input logic [1:0] e);
    chk_reg({30'h0, half_bridge_out}, {30'h0, e});
  endtask
  // Let the write edge land before looking at the combinational line.
  task automatic chk_irq(input logic e);
    #1;
    chk_reg({31'h0, irq}, {31'h0, e});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_run;
    for (int k = 0; k < 300 && fet_enable !== 1'b1; k++)
      cyc(1);
    // The flag is released one edge after the FETs come on.
    cyc(1);
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, oc} = 4'h0;
    flt = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    u_pwm_host.drive(2'b01, 1'b0);
    cyc(10);
    chk_pins(4'b0110);
    chk_out(2'b00);
    apb(1'b0, 8'h10, 32'h0);
    chk_reg(rd, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk_reg(rd, 32'h0);
    wait_run();
    chk_pins(4'hf);
    cyc(8);
    chk_out(2'b01);
    u_pwm_host.drive(2'b10, 1'b0);
    cyc(3);
    chk_out(2'b01);
    cyc(4);
    chk_out(2'b10);
    u_pwm_host.drive(2'b01, 1'b0);
    u_pwm_host.drive(2'b10, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      cyc(1);
      chk_out(2'b10);
    end
    apb(1'b1, 8'h04, 32'h40);
    u_pwm_host.drive(2'b10, 1'b1);
    cyc(2);
    chk_pins(4'b0111);
    chk_out(2'b00);
    chk_irq(1'b1);
    @(posedge clk) oc <= 1'b1;
    cyc(80);
    chk_pins(4'b0111);
    @(posedge clk) oc <= 1'b0;
    u_pwm_host.drive(2'b10, 1'b0);
    cyc(8);
    chk_pins(4'hf);
    chk_out(2'b10);
    apb(1'b0, 8'h00, 32'h0);
    chk_reg(rd, 32'h40);
    apb(1'b1, 8'h04, 32'h0);
    chk_irq(1'b0);
    apb(1'b1, 8'h04, 32'h40);
    chk_irq(1'b1);
    apb(1'b1, 8'h08, 32'h40);
    chk_irq(1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk_reg(rd, 32'h40);
    apb(1'b0, 8'h20, 32'h0);
    chk_reg({31'h0, err}, 32'h1);
    chk_reg(rd, 32'h0);
    @(posedge clk) oc <= 1'b1;
    cyc(55);
    chk_pins(4'hf);
    cyc(15);
    chk_pins(4'b0110);
    @(posedge clk) oc <= 1'b0;
    cyc(20);
    chk_pins(4'b0110);
    apb(1'b0, 8'h00, 32'h0);
    chk_reg(rd, 32'h08);
    u_pwm_host.pulse(20);
    cyc(4);
    chk_pins(4'hf);
    apb(1'b1, 8'h10, 32'h0);
    cyc(2);
    chk_pins(4'b0111);
    chk_out(2'b00);
    apb(1'b0, 8'h0c, 32'h0);
    chk_reg(rd, 32'h1a3);
    apb(1'b1, 8'h10, 32'h1);
    cyc(2);
    chk_pins(4'hf);
    chk_out(2'b10);
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk) flt[i] <= 1'b1;
      cyc(4);
      chk_pins(flt_exp[i]);
      @(posedge clk) flt <= 5'h0;
      wait_run();
      chk_pins(4'hf);
    end
    u_pwm_host.pin(1'b0);
    cyc(100);
    chk_pins(4'b0110);
    cyc(110);
    chk_pins(4'b0001);
    u_pwm_host.wake_up();
    wait_run();
    chk_pins(4'hf);
    finish_test();
  end
  initial
  begin
    #100000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
bind piezo_fault_ctrl piezo_fault_ctrl_sva #(.T_SLEEP_NS(T_SLEEP_NS)) u_piezo_fault_ctrl_sva (
  .clk, .rst, .half_bridge_cmd, .sleep_wake_n, .output_kill, .main_supply_uv, .ldo_rail_uv,
  .pump_rail_uv, .overcurrent_trip, .over_temp_fet, .over_temp_die, .fault_flag_oe_n,
  .half_bridge_out, .fet_enable, .pump_enable, .ldo_enable);
`default_nettype wire
